// *** rtl/async_serial_unit.sv ***
// Async serial data registers, rate generation and simple shifters
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module async_serial_unit (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        rxd,
    output logic             txd,
    output logic             txRateTick,
    output logic             rxRateTick
);
    logic                          ackFF;
    logic [31:0]                   readdataFF;
    logic [7:0]                    regIdx;
    logic [7:0]                    rdByte;
    logic                          accAny;
    logic                          rdAccept;
    logic                          wrAccept;
    serial_pkg::rate_select_type   rateFF;
    serial_pkg::link_control_type  linkFF;
    serial_pkg::serial_flags_type  flagsView;
    logic [7:0]                    rxFineFF;
    logic [7:0]                    txFineFF;
    logic                          txNinthFF;
    logic                          nineBitFF;
    logic                          wakeFF;
    logic                          flagsSeenFF;
    logic                          txClear;
    logic                          rxClear;
    logic [7:0]                    txHoldingFF;
    logic [7:0]                    rxHoldingFF;
    logic                          rxNinthFF;
    logic                          tdreFF;
    logic                          tcFF;
    logic                          rdrfFF;
    logic                          orFF;
    logic                          feFF;
    serial_pkg::tx_state_type      txStateFF;
    serial_pkg::rx_state_type      rxStateFF;
    logic [10:0]                   txShiftFF;
    logic [3:0]                    txBitsFF;
    logic [9:0]                    rxShiftFF;
    logic [9:0]                    rxFrame;
    logic [3:0]                    rxBitsFF;
    logic                          txLoad;
    logic                          txFrameEnd;
    logic                          rxStart;
    logic                          rxDone;
    logic                          rxdMetaFF;
    logic                          rxdSyncFF;
    logic                          txdFF;
    logic [3:0]                    preFactor;
    logic                          preTick;
    logic                          sixteenTick;
    logic                          txTick;
    logic                          rxTick;
    logic                          firstCycleFF;
    logic [3:0]                    txBitCountFF;
    logic [3:0]                    txFrameLenFF;

    // Two-cycle slave: request held, answered on the second edge
    assign waitrequest = (read | write) & ~ackFF;
    assign readdata    = readdataFF;
    assign regIdx      = address[serial_pkg::ADDR_W-1:serial_pkg::IDX_LSB];
    assign accAny      = (read | write) & ackFF;
    assign rdAccept    = read & ackFF;
    assign wrAccept    = write & ackFF & byteenable[0];
    assign txd         = txdFF;
    assign txRateTick  = txTick;
    assign rxRateTick  = rxTick;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ackFF <= 1'b0;
        else
            ackFF <= (read | write) & ~ackFF;
    end

    always_comb
    begin
        flagsView = '{txEmpty: tdreFF, txDone: tcFF, rxFull: rdrfFF,
                      idle: 1'b0, overrun: orFF, noise: 1'b0,
                      framing: feFF, unused: 1'b0};
        case (regIdx)
            serial_pkg::IDX_FLAGS:  rdByte = flagsView;
            // Data address reads the receive side
            serial_pkg::IDX_BUFFER: rdByte = rxHoldingFF;
            serial_pkg::IDX_RATE:   rdByte = rateFF;
            serial_pkg::IDX_FRAME:  rdByte = {rxNinthFF, txNinthFF, 1'b0,
                                              nineBitFF, wakeFF, 3'b000};
            serial_pkg::IDX_LINK:   rdByte = linkFF;
            serial_pkg::IDX_RXFINE: rdByte = rxFineFF;
            serial_pkg::IDX_TXFINE: rdByte = txFineFF;
            default:                rdByte = serial_pkg::BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            readdataFF <= {serial_pkg::READ_PAD, serial_pkg::BYTE_ZERO};
        else if (read && !ackFF)
            readdataFF <= {serial_pkg::READ_PAD, rdByte};
    end

    // Control resets; undefined bits also start at zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rateFF    <= serial_pkg::RATE_RESET;
            linkFF    <= serial_pkg::LINK_RESET;
            rxFineFF  <= serial_pkg::FINE_RESET;
            txFineFF  <= serial_pkg::FINE_RESET;
            txNinthFF <= 1'b0;
            nineBitFF <= 1'b0;
            wakeFF    <= 1'b0;
        end
        else if (wrAccept)
        begin
            case (regIdx)
                serial_pkg::IDX_RATE:   rateFF <= writedata[7:0];
                serial_pkg::IDX_LINK:   linkFF <= writedata[7:0];
                serial_pkg::IDX_RXFINE: rxFineFF <= writedata[7:0];
                serial_pkg::IDX_TXFINE: txFineFF <= writedata[7:0];
                serial_pkg::IDX_FRAME:
                begin
                    txNinthFF <= writedata[6];
                    nineBitFF <= writedata[4];
                    wakeFF    <= writedata[3];
                end
                default:
                begin
                end
            endcase
        end
    end

    // Arm on a flags access, disarm on any buffer access
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            flagsSeenFF <= 1'b0;
        else if (accAny && regIdx == serial_pkg::IDX_FLAGS)
            flagsSeenFF <= 1'b1;
        else if (accAny && regIdx == serial_pkg::IDX_BUFFER)
            flagsSeenFF <= 1'b0;
    end

    assign txClear = wrAccept && regIdx == serial_pkg::IDX_BUFFER
                     && flagsSeenFF;
    assign rxClear = rdAccept && regIdx == serial_pkg::IDX_BUFFER
                     && flagsSeenFF;

    always_comb
    begin
        case (rateFF.prescale)
            serial_pkg::PRE_SEL1: preFactor = serial_pkg::PRE_FACTOR1;
            serial_pkg::PRE_SEL3: preFactor = serial_pkg::PRE_FACTOR3;
            serial_pkg::PRE_SEL4: preFactor = serial_pkg::PRE_FACTOR4;
            default:              preFactor = serial_pkg::PRE_FACTOR13;
        endcase
    end

    tick_divider #(
        .WIDTH(4)
    ) preDiv (
        .mclk   (mclk),
        .rstn   (rstn),
        .inTick (1'b1),
        .divisor(preFactor),
        .outTick(preTick)
    );

    // Fixed sixteen stage shared by both directions
    tick_divider #(
        .WIDTH(5)
    ) sixteenDiv (
        .mclk   (mclk),
        .rstn   (rstn),
        .inTick (preTick),
        .divisor(serial_pkg::OVERSAMPLE),
        .outTick(sixteenTick)
    );

    rate_channel txChan (
        .mclk       (mclk),
        .rstn       (rstn),
        .sixteenTick(sixteenTick),
        .divField   (rateFF.txDiv),
        .fineDiv    (txFineFF),
        .rateTick   (txTick)
    );

    rate_channel rxChan (
        .mclk       (mclk),
        .rstn       (rstn),
        .sixteenTick(sixteenTick),
        .divField   (rateFF.rxDiv),
        .fineDiv    (rxFineFF),
        .rateTick   (rxTick)
    );

    // Data address writes only the transmit side
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            txHoldingFF <= serial_pkg::BYTE_ZERO;
        else if (wrAccept && regIdx == serial_pkg::IDX_BUFFER)
            txHoldingFF <= writedata[7:0];
    end

    // Load on a tick so the start bit lasts a full bit
    assign txLoad     = linkFF.txEn && txStateFF == serial_pkg::TX_IDLE
                        && !tdreFF && txTick;
    assign txFrameEnd = txStateFF == serial_pkg::TX_SHIFT && txTick
                        && txBitsFF == 4'h1;

    // Frame length from the word length bit
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            txStateFF <= serial_pkg::TX_IDLE;
            txShiftFF <= '1;
            txBitsFF  <= '0;
        end
        else
        begin
            case (txStateFF)
                serial_pkg::TX_IDLE:
                    if (txLoad)
                    begin
                        txStateFF <= serial_pkg::TX_SHIFT;
                        txShiftFF <= {1'b1, txNinthFF | ~nineBitFF,
                                      txHoldingFF, 1'b0};
                        txBitsFF  <= nineBitFF ? serial_pkg::FRAME_BITS9
                                               : serial_pkg::FRAME_BITS8;
                    end
                serial_pkg::TX_SHIFT:
                    if (txTick)
                    begin
                        txShiftFF <= {1'b1, txShiftFF[10:1]};
                        txBitsFF  <= txBitsFF - 1'b1;
                        if (txBitsFF == 4'h1)
                            txStateFF <= serial_pkg::TX_IDLE;
                    end
                default:
                    txStateFF <= serial_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            txdFF <= 1'b1;
        else if (txStateFF == serial_pkg::TX_SHIFT)
            txdFF <= txShiftFF[0];
        else
            txdFF <= ~(linkFF.txEn && linkFF.sendBreak);
    end

    // Tx flags: hardware set wins over the software clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tdreFF <= 1'b1;
            tcFF   <= 1'b1;
        end
        else
        begin
            if (txLoad)
                tdreFF <= 1'b1;
            else if (txClear)
                tdreFF <= 1'b0;
            if (txFrameEnd && tdreFF)
                tcFF <= 1'b1;
            else if (txClear)
                tcFF <= 1'b0;
        end
    end

    // Receive pin synchroniser
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxdMetaFF <= 1'b1;
            rxdSyncFF <= 1'b1;
        end
        else
        begin
            rxdMetaFF <= rxd;
            rxdSyncFF <= rxdMetaFF;
        end
    end

    // Samples once per bit on the free tick; phase is not centred
    assign rxStart = linkFF.rxEn && rxStateFF == serial_pkg::RX_IDLE
                     && !rxdSyncFF;
    assign rxDone  = rxStateFF == serial_pkg::RX_SHIFT && rxTick
                     && rxBitsFF == 4'h1;
    assign rxFrame = {rxdSyncFF, rxShiftFF[9:1]};

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxStateFF <= serial_pkg::RX_IDLE;
            rxShiftFF <= '0;
            rxBitsFF  <= '0;
        end
        else if (!linkFF.rxEn)
            rxStateFF <= serial_pkg::RX_IDLE;
        else
        begin
            case (rxStateFF)
                serial_pkg::RX_IDLE:
                    if (rxStart)
                    begin
                        rxStateFF <= serial_pkg::RX_SHIFT;
                        rxBitsFF  <= nineBitFF ? serial_pkg::FRAME_BITS8
                                       : serial_pkg::FRAME_BITS8 - 1'b1;
                    end
                serial_pkg::RX_SHIFT:
                    if (rxTick)
                    begin
                        rxShiftFF <= rxFrame;
                        rxBitsFF  <= rxBitsFF - 1'b1;
                        if (rxBitsFF == 4'h1)
                            rxStateFF <= serial_pkg::RX_IDLE;
                    end
                default:
                    rxStateFF <= serial_pkg::RX_IDLE;
            endcase
        end
    end

    // Overrun keeps the held character; new one is dropped
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxHoldingFF <= serial_pkg::BYTE_ZERO;
            rxNinthFF   <= 1'b0;
        end
        else if (rxDone && !rdrfFF)
        begin
            rxHoldingFF <= nineBitFF ? rxFrame[7:0] : rxFrame[8:1];
            rxNinthFF   <= nineBitFF & rxFrame[8];
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdrfFF <= 1'b0;
            orFF   <= 1'b0;
            feFF   <= 1'b0;
        end
        else if (!linkFF.rxEn)
        begin
            rdrfFF <= 1'b0;
            orFF   <= 1'b0;
            feFF   <= 1'b0;
        end
        else
        begin
            if (rxDone)
                rdrfFF <= 1'b1;
            else if (rxClear)
                rdrfFF <= 1'b0;
            if (rxDone && rdrfFF)
                orFF <= 1'b1;
            else if (rxClear)
                orFF <= 1'b0;
            if (rxDone && !rdrfFF)
                feFF <= ~rxFrame[9];
            else if (rxClear)
                feFF <= 1'b0;
        end
    end

    // Helpers read only by the checks below
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            firstCycleFF <= 1'b1;
            txBitCountFF <= '0;
            txFrameLenFF <= '0;
        end
        else
        begin
            firstCycleFF <= 1'b0;
            if (txLoad)
            begin
                txBitCountFF <= '0;
                txFrameLenFF <= nineBitFF ? serial_pkg::FRAME_BITS9
                                          : serial_pkg::FRAME_BITS8;
            end
            else if (txStateFF == serial_pkg::TX_SHIFT && txTick)
                txBitCountFF <= txBitCountFF + 1'b1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_flags_access;
        accAny && regIdx == serial_pkg::IDX_FLAGS;
    endsequence

    sequence s_buffer_write;
        wrAccept && regIdx == serial_pkg::IDX_BUFFER && flagsSeenFF
        && !txFrameEnd && !txLoad;
    endsequence

    a_write_loads_tx: assert property (
        wrAccept && regIdx == serial_pkg::IDX_BUFFER
        |=> txHoldingFF == $past(writedata[7:0]))
        else $error("buffer write did not load tx holding");

    a_write_keeps_rx: assert property (
        wrAccept && regIdx == serial_pkg::IDX_BUFFER && !rxDone
        |=> $stable(rxHoldingFF))
        else $error("buffer write disturbed rx holding");

    a_read_gives_rx: assert property (
        rdAccept && regIdx == serial_pkg::IDX_BUFFER
        |-> readdata[7:0] == $past(rxHoldingFF))
        else $error("buffer read not from rx holding");

    a_prescale_four: assert property (
        @(posedge mclk) disable iff (!rstn || wrAccept)
        preTick && rateFF.prescale == 2'h2
        |=> !preTick [*3] ##1 preTick)
        else $error("prescale by four period wrong");

    a_fine_reset_zero: assert property (
        firstCycleFF |-> rxFineFF == 8'h00 && txFineFF == 8'h00)
        else $error("fine dividers not zero after reset");

    a_prescale_reset: assert property (
        firstCycleFF |-> rateFF.prescale == 2'h0)
        else $error("prescale bits not zero after reset");

    a_status_reset: assert property (
        firstCycleFF |-> tdreFF && tcFF && !rdrfFF && linkFF == 8'h00)
        else $error("status or link control reset wrong");

    a_frame_length: assert property (
        txFrameEnd |-> txBitCountFF == txFrameLenFF - 1'b1
                       && (txFrameLenFF == 4'hA || txFrameLenFF == 4'hB))
        else $error("transmit frame length wrong");

    a_status_clear: assert property (
        s_flags_access ##[1:16] s_buffer_write |=> !tdreFF && !tcFF)
        else $error("tx flags not cleared by sequence");
endmodule

// *** rtl/serial_pkg.sv ***
// Shared constants and types for the async serial rate and data block
// Overview of operation
// - Writing the char buffer loads tx holding only, never rx holding
// - Reading the char buffer returns rx holding, filled by the receiver
// - Prescale field bits 7:6 divide by 1, 3, 4 or 13
// - Tx divisor field bits 5:3 divides by two to its power
// - Rx divisor field bits 2:0 divides by two to its power
// - Tx divisor applies only while tx fine divider is zero
// - Rx divisor applies only while rx fine divider is zero
// - Non-zero rx fine divider divides the sixteen stage by its value
// - Non-zero tx fine divider divides the sixteen stage by its value
// - Both fine dividers reset to zero
// - Prescale bits reset to zero; divisor and data bits are undefined
// - Link control resets to zero; flags reset with both tx flags set
// - Word length bit picks eight or nine data bits, one stop
// - Flags access then buffer write clears tx empty and tx done
package serial_pkg;
    localparam int         ADDR_W      = 10;
    localparam int         IDX_LSB     = 2;
    localparam logic [7:0] IDX_FLAGS   = 8'h50;
    localparam logic [7:0] IDX_BUFFER  = 8'h51;
    localparam logic [7:0] IDX_RATE    = 8'h52;
    localparam logic [7:0] IDX_FRAME   = 8'h53;
    localparam logic [7:0] IDX_LINK    = 8'h54;
    localparam logic [7:0] IDX_RXFINE  = 8'h55;
    localparam logic [7:0] IDX_TXFINE  = 8'h57;
    localparam logic [23:0] READ_PAD   = 24'h00_0000;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [7:0] LINK_RESET  = 8'h00;
    localparam logic [7:0] FINE_RESET  = 8'h00;
    localparam logic [7:0] RATE_RESET  = 8'h00;
    localparam logic [3:0] PRE_FACTOR1  = 4'h1;
    localparam logic [3:0] PRE_FACTOR3  = 4'h3;
    localparam logic [3:0] PRE_FACTOR4  = 4'h4;
    localparam logic [3:0] PRE_FACTOR13 = 4'hD;
    localparam logic [1:0] PRE_SEL1    = 2'h0;
    localparam logic [1:0] PRE_SEL3    = 2'h1;
    localparam logic [1:0] PRE_SEL4    = 2'h2;
    localparam logic [4:0] OVERSAMPLE  = 5'h10;
    localparam logic [3:0] FRAME_BITS8 = 4'hA;
    localparam logic [3:0] FRAME_BITS9 = 4'hB;

    typedef struct packed {
        logic [1:0] prescale;
        logic [2:0] txDiv;
        logic [2:0] rxDiv;
    } rate_select_type;

    typedef struct packed {
        logic txIe;
        logic doneIe;
        logic rxIe;
        logic idleIe;
        logic txEn;
        logic rxEn;
        logic mute;
        logic sendBreak;
    } link_control_type;

    typedef struct packed {
        logic txEmpty;
        logic txDone;
        logic rxFull;
        logic idle;
        logic overrun;
        logic noise;
        logic framing;
        logic unused;
    } serial_flags_type;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b01,
        RX_SHIFT = 2'b10
    } rx_state_type;
endpackage

// *** rtl/tick_divider.sv ***
// Enable-pulse divider: one output pulse per divisor input pulses
`timescale 1ns/1ns
module tick_divider #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             inTick,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  outTick
);
    logic [WIDTH-1:0] cntFF;
    logic             lastStep;

    // Compare at or above, so a smaller divisor ends the bit early
    assign lastStep = (divisor <= WIDTH'(1)) || (cntFF >= divisor - 1'b1);
    assign outTick  = inTick && lastStep;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cntFF <= '0;
        end
        else if (outTick)
        begin
            cntFF <= '0;
        end
        else if (inTick)
        begin
            cntFF <= cntFF + 1'b1;
        end
    end
endmodule

// *** rtl/rate_channel.sv ***
// One direction's rate clock: power-of-two or fine divider selection
`timescale 1ns/1ns
module rate_channel (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       sixteenTick,
    input  wire logic [2:0] divField,
    input  wire logic [7:0] fineDiv,
    output logic            rateTick
);
    logic [7:0] divisor;
    logic [8:0] seenFF;
    logic [7:0] lastDivFF;
    logic       changedFF;

    // Fine divider overrides power of two
    assign divisor = (fineDiv != serial_pkg::FINE_RESET) ? fineDiv
                                                          : 8'h01 << divField;

    tick_divider #(
        .WIDTH(8)
    ) rateDiv (
        .mclk   (mclk),
        .rstn   (rstn),
        .inTick (sixteenTick),
        .divisor(divisor),
        .outTick(rateTick)
    );

    // Period watch for the checks below
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            seenFF    <= '0;
            lastDivFF <= '0;
            changedFF <= 1'b1;
        end
        else
        begin
            lastDivFF <= divisor;
            if (rateTick)
            begin
                seenFF    <= '0;
                changedFF <= 1'b0;
            end
            else
            begin
                if (sixteenTick)
                    seenFF <= seenFF + 1'b1;
                if (divisor != lastDivFF)
                    changedFF <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_conv_period: assert property (
        rateTick && !changedFF && divisor == lastDivFF && fineDiv == 8'h00
        |-> 9'(seenFF + 1'b1) == (9'h001 << divField))
        else $error("conventional rate period wrong");

    a_fine_period: assert property (
        rateTick && !changedFF && divisor == lastDivFF && fineDiv != 8'h00
        |-> 9'(seenFF + 1'b1) == {1'b0, fineDiv})
        else $error("fine rate period wrong");
endmodule

// *** test/remote_sender.sv ***
// Remote serial sender driving the receive line
`timescale 1ns/1ns
module remote_sender (
    input  wire logic       mclk,
    input  wire logic       tick,
    input  wire logic       go,
    input  wire logic [7:0] data,
    output logic            line
);
    int i;
    initial
    begin
        line = 1'h1;
        forever
        begin
            @(posedge mclk);
            if (go)
            begin
                // Phase locked, receiver does not centre
                do
                    @(negedge mclk);
                while (tick !== 1'h1);
                repeat (2) @(posedge mclk);
                line <= 1'h0;
                repeat (6) @(posedge mclk);
                for (i = 0; i < 9; i++)
                begin
                    line <= (i < 8) ? data[i] : 1'h1;
                    repeat (16) @(posedge mclk);
                end
            end
        end
    end
endmodule

// *** test/async_serial_unit_tb.sv ***
// Self-checking bench for the async serial unit
`timescale 1ns/1ns
module async_serial_unit_tb;
    logic        mclk = 1'h0;
    logic        rstn = 1'h0;
    logic [9:0]  address = 10'h000;
    logic        read = 1'h0;
    logic        write = 1'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic        waitrequest, rxd, txd, txRateTick, rxRateTick;
    logic        go = 1'h0;
    logic [7:0]  sent = 8'h00;
    logic [7:0]  q;
    logic [31:0] seed = 32'h0000_9d14;
    int          fail_count = 0;
    int          n_checks = 0;
    int          pf[4] = '{1, 3, 4, 13};
    int          p, k, t, r, f;
    int          rxq[$];

    async_serial_unit dut (.mclk(mclk), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
        .rxd(rxd), .txd(txd), .txRateTick(txRateTick),
        .rxRateTick(rxRateTick));
    remote_sender peer (.mclk(mclk), .tick(rxRateTick), .go(go),
        .data(sent), .line(rxd));

    always #50 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic bus(bit w, logic [7:0] idx, logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        address <= {idx, 2'h0};
        writedata <= {24'h00_0000, d};
        read <= ~w;
        write <= w;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (waitrequest !== 1'h0 && n < 50);
        if (waitrequest !== 1'h0)
        begin
            fail_count++;
            conclude();
        end
        q = readdata[7:0];
        read <= 1'h0;
        write <= 1'h0;
    endtask

    // Interval between the last two rate pulses
    task automatic period(bit rx);
        int c, last;
        c = 0;
        last = 0;
        for (k = 0; k < 9000 && c < 3; k++)
        begin
            @(negedge mclk);
            if ((rx ? rxRateTick : txRateTick) === 1'h1)
            begin
                c++;
                p = k - last;
                last = k;
            end
        end
        if (c < 3)
        begin
            fail_count++;
            conclude();
        end
    endtask

    initial
    begin
        repeat (10) @(posedge mclk);
        rstn <= 1'h1;
        bus(0, 8'h50, 0);
        chk("flags", q, 8'hC0);
        bus(0, 8'h54, 0);
        chk("link", q, 0);
        bus(0, 8'h55, 0);
        chk("rxfine", q, 0);
        bus(0, 8'h57, 0);
        chk("txfine", q, 0);
        bus(0, 8'h52, 0);
        chk("prescale", q & 8'hC0, 0);
        for (int s = 0; s < 4; s++)
        begin
            t = rnd() % 3;
            r = rnd() % 3;
            bus(1, 8'h52, {s[1:0], t[2:0], r[2:0]});
            period(0);
            chk("txrate", p, 16 * pf[s] << t);
            period(1);
            chk("rxrate", p, 16 * pf[s] << r);
        end
        f = rnd() % 4 + 1;
        bus(1, 8'h57, f[7:0]);
        period(0);
        chk("txfinerate", p, 16 * 13 * f);
        bus(1, 8'h57, 0);
        period(0);
        chk("txconv", p, 16 * 13 << t);
        bus(1, 8'h55, f[7:0]);
        period(1);
        chk("rxfinerate", p, 16 * 13 * f);
        bus(1, 8'h52, 0);
        bus(1, 8'h55, 1);
        bus(1, 8'h54, 8'h04);
        bus(1, 8'h51, 8'hA5);
        f = rnd() % 256;
        rxq.push_back(f);
        sent <= f[7:0];
        go <= 1'h1;
        @(posedge mclk);
        go <= 1'h0;
        q = 8'h00;
        for (k = 0; k < 100 && q[5] !== 1'h1; k++)
            bus(0, 8'h50, 0);
        if (q[5] !== 1'h1)
        begin
            fail_count++;
            conclude();
        end
        bus(0, 8'h51, 0);
        chk("rxhold", q, rxq[0]);
        bus(1, 8'h51, 8'h3C);
        bus(0, 8'h51, 0);
        chk("rxkeep", q, rxq.pop_front());
        bus(0, 8'h50, 0);
        bus(1, 8'h51, 8'h5A);
        bus(0, 8'h50, 0);
        chk("txflags", q & 8'hC0, 0);
        // Nine-bit frame with ninth bit clear, sent at sixteen cycles a bit
        bus(1, 8'h53, 8'h10);
        bus(1, 8'h54, 8'h0C);
        for (k = 0; k < 100 && txd !== 1'h0; k++)
            @(negedge mclk);
        if (txd !== 1'h0)
        begin
            fail_count++;
            conclude();
        end
        repeat (8) @(negedge mclk);
        for (k = 0; k < 11; k++)
        begin
            r = (k == 0 || k == 9) ? 0 : (k == 10) ? 1
                : (8'h5A >> (k - 1)) & 1;
            chk("txbit", txd, r);
            repeat (16) @(negedge mclk);
        end
        bus(0, 8'h50, 0);
        chk("txdone", q & 8'hC0, 8'hC0);
        conclude();
    end
endmodule
